// ==== clock_ctrl_pkg.sv ====
// Functional notes
// [RULE1] reset selects internal oscillator, select bit zero
// [RULE2] select bit one chooses external source
// [RULE3] status bit shows active external selection
// [RULE4] source changeover is glitch free
// [RULE5] software switches only to stable source
// [RULE6] eight-bit signed trim offset in bits 0-7; code adds the field to the capacitor preset as an unsigned value
// [RULE7] trim resets to 128, capacitor 432
// [RULE8] one trim step about 0.2 percent
// [RULE9] software waits for pll settling
// [RULE10] software keeps core clock within 80 MHz
// [RULE11] reset held 275000 or 128 cycles
// [RULE12] external bus tristated during reset
// [RULE13] first address 33 to 34 cycles
// [RULE14] stabilization delay on power-on and stop exit; code delays only with refSel set, which reset clears
// [RULE15] stop exit fetch within 275000 or 12
// [RULE16] edge request held 1.5 cycles
// [RULE17] stop wake request held two cycles
// [RULE18] wait wake vector no sooner than 13
// [RULE19] service access 15, output 16 cycles
// [RULE20] level request held until fetch
// [RULE21] fetch visible on pins only in mode 3
// [RULE22] select bit at pll control bit 2
// [RULE23] delays counted by 19-bit cycle counter
// [RULE24] trim write takes effect immediately
package clock_ctrl_pkg;
  localparam int unsigned ADDR_W         = 4;
  localparam int unsigned DATA_W         = 16;
  localparam logic [3:0]  ADDR_PLL_CTRL  = 4'h0;
  localparam logic [3:0]  ADDR_PLL_STAT  = 4'h1;
  localparam logic [3:0]  ADDR_OSC_TRIM  = 4'h2;
  localparam logic [3:0]  ADDR_MODE      = 4'h3;
  localparam logic [3:0]  ADDR_STATE     = 4'h4;
  localparam int unsigned REF_SEL_BIT    = 2;
  localparam int unsigned REF_STAT_BIT   = 2;
  localparam int unsigned FAST_WAKE_BIT  = 6;
  localparam int unsigned MODE_LO        = 0;
  localparam int unsigned MODE_HI        = 1;
  localparam logic [1:0]  MODE_VISIBLE   = 2'h3;
  localparam logic [7:0]  TRIM_RESET     = 8'h80;
  localparam logic [9:0]  CAP_PRESET     = 10'h130;
  localparam int unsigned CNT_W          = 19;
  localparam int unsigned LONG_DELAY     = 275000;
  localparam int unsigned SHORT_RESET    = 128;
  localparam int unsigned FAST_WAKE      = 12;
  localparam int unsigned ADDR_OUT_DELAY = 33;
  localparam int unsigned WAIT_VECTOR    = 13;
  localparam int unsigned DATA_ACCESS    = 15;
  localparam int unsigned GPIO_VALID     = 16;
  localparam int unsigned SYNC_STAGES    = 2;
  typedef enum logic [2:0] {
    ST_RESET, ST_BOOT, ST_RUN, ST_WAIT, ST_STOP, ST_WAKE, ST_SERVICE
  } pwr_state_type;
endpackage : clock_ctrl_pkg

// ==== glitch_free_mux.sv ====
`timescale 1ns/1ps
// glitch-free two-source changeover: each side's enable is released only
// after the other side has been turned off, each resynchronised
module glitch_free_mux
  import clock_ctrl_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic selExt,
  input  wire logic refInt,
  input  wire logic refExt,
  output logic      enInt,
  output logic      enExt,
  output logic      refOut
);
  logic [SYNC_STAGES-1:0] syncInt;
  logic [SYNC_STAGES-1:0] syncExt;
  logic [SYNC_STAGES-1:0] next_syncInt;
  logic [SYNC_STAGES-1:0] next_syncExt;

  always_comb begin
    next_syncInt = {syncInt[0], ~selExt & ~syncExt[SYNC_STAGES-1]};
    next_syncExt = {syncExt[0], selExt & ~syncInt[SYNC_STAGES-1]};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      syncInt <= 2'h0;
      syncExt <= 2'h0;
    end else if (ce) begin
      syncInt <= next_syncInt;
      syncExt <= next_syncExt;
    end
  end

  assign enInt  = syncInt[SYNC_STAGES-1];
  assign enExt  = syncExt[SYNC_STAGES-1];
  assign refOut = (refInt & enInt) | (refExt & enExt); // RULE4

  a_mux_exclusive: assert property (@(posedge clk) disable iff (srst) // RULE4
    !(enInt && enExt))
    else $error("both reference enables high");
endmodule : glitch_free_mux

// ==== clock_ctrl.sv ====
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module clock_ctrl
  import clock_ctrl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic              refIntClk,
  input  wire logic              refExtClk,
  input  wire logic              extIrqA_n,
  input  wire logic              extIrqB_n,
  input  wire logic              stopReq,
  input  wire logic              waitReq,
  input  wire logic              powerOnReset,
  output logic                   refClk,
  output logic                   relaxOscEn,
  output logic                   extOscEn,
  output logic      [9:0]        oscCapSetting,
  output logic                   busOe,
  output logic                   addrValid,
  output logic                   vectorValid,
  output logic                   fetchVisible,
  output logic                   dataAccessValid,
  output logic                   gpioValid
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] irqASync;
  logic [1:0] irqBSync;
  logic       irqAPrev;
  logic       ext_irq_a;
  logic       ext_irq_b;
  logic       irqAFall;
  logic       irqAHeld;

  always_ff @(posedge clk) begin
    if (srst) begin
      irqASync <= 2'h3;
      irqBSync <= 2'h3;
      irqAPrev <= 1'b0;
    end else if (ce) begin
      irqASync <= {irqASync[0], extIrqA_n};
      irqBSync <= {irqBSync[0], extIrqB_n};
      irqAPrev <= ext_irq_a;
    end
  end

  assign ext_irq_a     = ~irqASync[1];
  assign ext_irq_b     = ~irqBSync[1];
  assign irqAFall = ext_irq_a & ~irqAPrev;
  assign irqAHeld = ext_irq_a & irqAPrev; // RULE17

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic             refSel;
  logic [7:0]       trim;
  logic [DATA_W-1:0] modeWord;
  logic             extStable;
  logic             next_refSel;
  logic [7:0]       next_trim;
  logic [DATA_W-1:0] next_modeWord;
  logic [DATA_W-1:0] next_rdata;
  logic             enInt;
  logic             enExt;
  logic             refMux;
  pwr_state_type    state;
  pwr_state_type    next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             fastWake;

  assign fastWake = modeWord[FAST_WAKE_BIT];

  always_comb begin
    next_refSel   = refSel;
    next_trim     = trim;
    next_modeWord = modeWord;
    next_rdata    = '0;
    if (wr) begin
      case (addr)
        ADDR_PLL_CTRL: next_refSel = wdata[REF_SEL_BIT]; // RULE2 RULE22
        ADDR_OSC_TRIM: next_trim = wdata[7:0]; // RULE6
        ADDR_MODE:     next_modeWord = wdata;
        default:       ;
      endcase
    end
    if (rd) begin
      case (addr)
        ADDR_PLL_CTRL: next_rdata[REF_SEL_BIT] = refSel;
        ADDR_PLL_STAT: next_rdata[REF_STAT_BIT] = enExt; // RULE3
        ADDR_OSC_TRIM: next_rdata[7:0] = trim;
        ADDR_MODE:     next_rdata = modeWord;
        ADDR_STATE:    next_rdata[2:0] = state;
        default:       next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      refSel   <= 1'b0; // RULE1
      trim     <= TRIM_RESET; // RULE7
      modeWord <= '0;
      rdata    <= '0;
    end else if (ce) begin
      refSel   <= next_refSel;
      trim     <= next_trim;
      modeWord <= next_modeWord;
      rdata    <= next_rdata;
    end
  end

  glitch_free_mux u_mux (
    .clk    (clk),
    .srst   (srst),
    .ce     (ce),
    .selExt (refSel),
    .refInt (refIntClk),
    .refExt (refExtClk),
    .enInt  (enInt),
    .enExt  (enExt),
    .refOut (refMux)
  );

  ////////////////////////////////////////////////////////////////////////
  // reset, stop and wake sequencer
  logic       next_busOe;
  logic       next_addrValid;
  logic       next_vectorValid;
  logic       next_fetchVisible;
  logic       next_dataAccessValid;
  logic       next_gpioValid;
  logic       needStab;
  logic       next_needStab;

  always_comb begin
    next_state           = state;
    next_cnt             = cnt + 1'b1; // RULE23
    next_needStab        = needStab;
    next_busOe           = busOe;
    next_addrValid       = addrValid;
    next_vectorValid     = 1'b0;
    next_fetchVisible    = 1'b0;
    next_dataAccessValid = 1'b0;
    next_gpioValid       = 1'b0;
    case (state)
      ST_RESET: begin
        next_state = ST_BOOT;
        next_cnt   = '0;
      end
      ST_BOOT: begin
        // stabilization on power-on with external reference
        if (cnt == CNT_W'(ADDR_OUT_DELAY - 1) && !(needStab && refSel)) begin // RULE13 RULE14
          next_state     = ST_RUN;
          next_busOe     = 1'b1;
          next_addrValid = 1'b1;
          next_needStab  = 1'b0;
        end else if (cnt == CNT_W'(LONG_DELAY - 1)) begin
          next_needStab = 1'b0;
          next_cnt      = '0;
        end
      end
      ST_RUN: begin
        next_cnt = '0;
        if (stopReq)      next_state = ST_STOP;
        else if (waitReq) next_state = ST_WAIT;
        else if (ext_irq_a || ext_irq_b) next_state = ST_SERVICE;
      end
      ST_WAIT: begin
        if (irqAFall) begin
          next_state = ST_WAKE;
          next_cnt   = '0;
        end
      end
      ST_STOP: begin
        next_cnt = '0;
        if (irqAHeld) begin // RULE17 RULE20
          next_state = ST_WAKE;
          next_needStab = refSel; // RULE14
        end
      end
      ST_WAKE: begin
        if (needStab) begin
          if (cnt == CNT_W'((fastWake ? FAST_WAKE : LONG_DELAY) - 1)) begin // RULE15
            next_state        = ST_SERVICE;
            next_needStab     = 1'b0;
            next_vectorValid  = 1'b1;
            next_fetchVisible = (modeWord[MODE_HI:MODE_LO] == MODE_VISIBLE); // RULE21
            next_cnt          = '0;
          end
        end else if (cnt == CNT_W'(WAIT_VECTOR - 1) || fastWake && cnt == CNT_W'(FAST_WAKE - 1)
                     && WAIT_VECTOR <= FAST_WAKE) begin // RULE18
          next_state        = ST_SERVICE;
          next_vectorValid  = 1'b1;
          next_fetchVisible = (modeWord[MODE_HI:MODE_LO] == MODE_VISIBLE); // RULE21
          next_cnt          = '0;
        end
      end
      ST_SERVICE: begin
        if (cnt == CNT_W'(DATA_ACCESS - 1)) next_dataAccessValid = 1'b1; // RULE19
        if (cnt == CNT_W'(GPIO_VALID - 1)) begin
          next_gpioValid = 1'b1; // RULE19
          next_state     = ST_RUN;
        end
      end
      default: next_state = ST_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state           <= ST_RESET;
      cnt             <= '0;
      busOe           <= 1'b0; // RULE12
      addrValid       <= 1'b0;
      vectorValid     <= 1'b0;
      fetchVisible    <= 1'b0;
      dataAccessValid <= 1'b0;
      gpioValid       <= 1'b0;
    end else if (ce) begin
      state           <= next_state;
      cnt             <= next_cnt;
      busOe           <= next_busOe;
      addrValid       <= next_addrValid;
      vectorValid     <= next_vectorValid;
      fetchVisible    <= next_fetchVisible;
      dataAccessValid <= next_dataAccessValid;
      gpioValid       <= next_gpioValid;
    end
  end

  // power-on request is a same-domain strap caught while in reset
  always_ff @(posedge clk) begin
    if (srst) needStab <= powerOnReset; // RULE14
    else if (ce) needStab <= next_needStab;
  end

  ////////////////////////////////////////////////////////////////////////
  // clock and oscillator outputs
  // capacitor setting is the preset plus the raw trim field
  always_ff @(posedge clk) begin
    if (srst) begin
      refClk        <= 1'b0;
      relaxOscEn    <= 1'b1; // RULE1
      extOscEn      <= 1'b0;
      oscCapSetting <= CAP_PRESET + 10'(TRIM_RESET); // RULE7
    end else if (ce) begin
      refClk        <= refMux;
      relaxOscEn    <= ~refSel | enInt;
      extOscEn      <= 1'b1;
      oscCapSetting <= CAP_PRESET + 10'(next_trim); // RULE6 RULE8 RULE24
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_reset_tristate: assert property (@(posedge clk) srst |=> !busOe) // RULE12
    else $error("bus driven after reset");
  a_sel_reset: assert property (@(posedge clk) srst |=> !refSel && trim == TRIM_RESET) // RULE1 RULE7
    else $error("reset values wrong");
  a_sel_write: assert property (@(posedge clk) disable iff (srst) // RULE2
    ce && wr && addr == ADDR_PLL_CTRL |=> refSel == $past(wdata[REF_SEL_BIT]))
    else $error("select write lost");
  a_status_follow: assert property (@(posedge clk) disable iff (srst) // RULE3
    ce && refSel && !enInt |-> ##[1:3] (enExt || !refSel))
    else $error("external status late");
  a_trim_write: assert property (@(posedge clk) disable iff (srst) // RULE24
    ce && wr && addr == ADDR_OSC_TRIM |=> trim == $past(wdata[7:0]))
    else $error("trim write lost");
  sequence s_boot_start;
    state == ST_RESET && !srst && ce;
  endsequence
  a_first_addr: assert property (@(posedge clk) disable iff (srst || !ce) // RULE13
    (s_boot_start and !needStab) |-> ##[33:34] addrValid)
    else $error("first address timing");
  a_wait_vector: assert property (@(posedge clk) disable iff (srst || !ce) // RULE18
    state == ST_WAIT && irqAFall |=> !vectorValid [*8] ##1 !vectorValid [*5])
    else $error("vector too early");
  a_service_gpio: assert property (@(posedge clk) disable iff (srst || !ce) // RULE19
    state != ST_SERVICE ##1 state == ST_SERVICE |-> !gpioValid [*8] ##1 !gpioValid [*8])
    else $error("gpio too early");
  a_fast_stop: assert property (@(posedge clk) disable iff (srst || !ce) // RULE15
    state == ST_STOP && irqAHeld && fastWake |-> ##[1:14] state == ST_SERVICE)
    else $error("fast stop exit late");
  a_cap_track: assert property (@(posedge clk) disable iff (srst) // RULE6 RULE24
    oscCapSetting == CAP_PRESET + 10'(trim))
    else $error("capacitor setting off trim");
  a_boot_quiet: assert property (@(posedge clk) disable iff (srst) // RULE12 RULE13
    state == ST_BOOT |-> !busOe && !addrValid)
    else $error("bus driven during boot");
  // stop exit needs the request seen on two samples
  sequence s_stop_leave;
    state == ST_STOP ##1 state == ST_WAKE;
  endsequence
  a_stop_width: assert property (@(posedge clk) disable iff (srst || !ce) // RULE17
    s_stop_leave |-> $past(ext_irq_a) && $past(ext_irq_a, 2))
    else $error("stop left on short request");
endmodule : clock_ctrl

// ==== irq_source.sv ====
`timescale 1ns/1ps
module irq_source (
  input  wire logic       clk,
  input  wire logic       fireA,
  input  wire logic       fireB,
  input  wire logic [7:0] width,
  output logic            extIrqA_n,
  output logic            extIrqB_n
);
  logic [7:0] cntA = 8'h00;
  logic [7:0] cntB = 8'h00;
  // each request is held low for width cycles, with no minimum width
  always @(posedge clk) begin
    if (fireA) cntA <= width;
    else if (cntA != 8'h00) cntA <= cntA - 8'h01;
    if (fireB) cntB <= width;
    else if (cntB != 8'h00) cntB <= cntB - 8'h01;
  end
  assign extIrqA_n = (cntA == 8'h00);
  assign extIrqB_n = (cntB == 8'h00);
endmodule : irq_source

// ==== tb.sv ====
`timescale 1ns/1ps
module tb
  import clock_ctrl_pkg::*;
;
  logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, d;
  logic refIntClk = 1'b0, refExtClk = 1'b0, stopReq = 1'b0, waitReq = 1'b0;
  logic fireA = 1'b0, fireB = 1'b0, extIrqA_n, extIrqB_n;
  logic refClk, relaxOscEn, extOscEn, busOe, addrValid, vectorValid;
  logic fetchVisible, dataAccessValid, gpioValid, fv, powerOnReset = 1'b0;
  logic [9:0] oscCapSetting;
  int fails = 0, total_checks = 0, cyc = 0, t0, tA, tV, tD, tG;
  clock_ctrl clock_ctrl_i (.clk(clk), .srst(srst), .ce(1'b1), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .refIntClk(refIntClk), .refExtClk(refExtClk),
    .extIrqA_n(extIrqA_n), .extIrqB_n(extIrqB_n), .stopReq(stopReq), .waitReq(waitReq),
    .powerOnReset(powerOnReset), .refClk(refClk), .relaxOscEn(relaxOscEn), .extOscEn(extOscEn),
    .oscCapSetting(oscCapSetting), .busOe(busOe), .addrValid(addrValid),
    .vectorValid(vectorValid), .fetchVisible(fetchVisible),
    .dataAccessValid(dataAccessValid), .gpioValid(gpioValid));
  irq_source irq_source_i (.clk(clk), .fireA(fireA), .fireB(fireB), .width(8'h14),
    .extIrqA_n(extIrqA_n), .extIrqB_n(extIrqB_n));
  initial begin
    forever #50 clk = ~clk;
  end
  // references change on falling clock edges only
  always #200 refIntClk = ~refIntClk;
  always #100 refExtClk = ~refExtClk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (addrValid && tA == 0) tA <= cyc;
    if (vectorValid && tV == 0) tV <= cyc;
    if (dataAccessValid && tD == 0) tD <= cyc;
    if (gpioValid && tG == 0) tG <= cyc;
    if (fetchVisible) fv <= 1'b1;
    if (cyc > 20000) begin
      fails++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  // three edges tell the two references apart
  task automatic chk_ref(input logic useExt);
    repeat (3) begin
      @(posedge clk);
      #1 chk("refClk", useExt ? refExtClk : refIntClk, refClk);
    end
  endtask : chk_ref
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  // pulse the irq source, wait for the wake and service sequence to finish
  task automatic wake_irq();
    tV = 0; tD = 0; tG = 0; fv = 1'b0;
    @(posedge clk);
    fireA <= 1'b1;
    @(posedge clk);
    fireA <= 1'b0;
    t0 = cyc;
    repeat (80) @(posedge clk);
    waitReq <= 1'b0;
    stopReq <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : wake_irq
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    tA = 0;
    repeat (20) @(posedge clk);
    #1 chk("busOe", 0, busOe);
    @(posedge clk);
    srst <= 1'b0;
    t0 = cyc + 1;
    repeat (50) @(posedge clk);
    chk("addr delay ok", 1, (tA - t0 >= 33) && (tA - t0 <= 34));
    rd_reg(ADDR_PLL_CTRL, d);
    chk("ref select", 0, d[2]);
    chk("relaxOscEn", 1, relaxOscEn);
    chk_ref(1'b0);
    rd_reg(ADDR_OSC_TRIM, d);
    chk("trim reset", 16'h0080, d);
    chk("cap reset", 10'h1b0, oscCapSetting);
    rd_reg(4'hf, d);
    chk("unmapped", 0, d);
    $display("test reset done");
  endtask : test_reset
  task automatic test_trim();
    wr_reg(ADDR_OSC_TRIM, 16'h0085);
    @(posedge clk);
    #1 chk("cap up", 10'h1b5, oscCapSetting);
    wr_reg(ADDR_OSC_TRIM, 16'h007b);
    @(posedge clk);
    #1 chk("cap down", 10'h1ab, oscCapSetting);
    rd_reg(ADDR_OSC_TRIM, d);
    chk("trim read", 16'h007b, d);
    $display("test trim done");
  endtask : test_trim
  task automatic test_wait_wake();
    wr_reg(ADDR_MODE, 16'h0000);
    waitReq <= 1'b1;
    @(posedge clk);
    waitReq <= 1'b0;
    rd_reg(ADDR_STATE, d);
    chk("in wait", ST_WAIT, d[2:0]);
    wake_irq();
    chk("vector late", 1, tV != 0 && tV - t0 >= 13);
    chk("data access", 1, tD != 0 && tD - t0 >= 15);
    chk("gpio valid", 1, tG != 0 && tG - t0 >= 16);
    chk("fetch hidden", 0, fv);
    $display("test wait wake done");
  endtask : test_wait_wake
  task automatic test_ext_stop();
    wr_reg(ADDR_PLL_CTRL, 16'h0004);
    repeat (10) @(posedge clk);
    rd_reg(ADDR_PLL_STAT, d);
    chk("sel status", 1, d[2]);
    chk("extOscEn", 1, extOscEn);
    chk("relaxOscEn off", 0, relaxOscEn);
    chk_ref(1'b1);
    wr_reg(ADDR_MODE, 16'h0043);
    stopReq <= 1'b1;
    @(posedge clk);
    stopReq <= 1'b0;
    rd_reg(ADDR_STATE, d);
    chk("in stop", ST_STOP, d[2:0]);
    wake_irq();
    chk("stop fetch", 1, tV != 0 && tV - t0 <= FAST_WAKE + SYNC_STAGES + 4);
    chk("fetch shown", 1, fv);
    $display("test ext stop done");
  endtask : test_ext_stop
  task automatic test_rerst();
    @(posedge clk);
    srst <= 1'b1;
    powerOnReset <= 1'b1;
    repeat (128) @(posedge clk);
    tA = 0;
    #1 chk("busOe in reset", 0, busOe);
    @(posedge clk);
    srst <= 1'b0;
    powerOnReset <= 1'b0;
    t0 = cyc + 1;
    repeat (50) @(posedge clk);
    chk("rerst addr ok", 1, (tA - t0 >= 33) && (tA - t0 <= 34));
    rd_reg(ADDR_PLL_CTRL, d);
    chk("rerst select", 0, d[2]);
    chk("rerst relaxOscEn", 1, relaxOscEn);
    rd_reg(ADDR_OSC_TRIM, d);
    chk("rerst trim", 16'h0080, d);
    chk("rerst cap", 10'h1b0, oscCapSetting);
    chk_ref(1'b0);
    $display("test rerst done");
  endtask : test_rerst
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  initial begin
    test_reset();
    test_trim();
    test_wait_wake();
    test_ext_stop();
    test_rerst();
    summarize();
  end
endmodule : tb
